/* File: rtl/cpsc_pkg.sv */
// Shared constants, states and carrier types for the cache policy and scratchpad controller
package cpsc_pkg;

  // Geometry of one cache side
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned LINE_BYTES = 16;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned WAY_BYTES  = 4096;
  localparam int unsigned SP_BYTES   = 1048576;
  localparam int unsigned WAYS       = 2;
  localparam int unsigned SP_WAY     = 1;    // Way that the scratchpad replaces
  localparam int unsigned WORDS      = LINE_BYTES / WORD_BYTES;
  localparam int unsigned SETS       = WAY_BYTES / LINE_BYTES;
  localparam int unsigned OFS_W      = $clog2(LINE_BYTES);
  localparam int unsigned WSEL_W     = $clog2(WORDS);
  localparam int unsigned IDX_W      = $clog2(SETS);
  localparam int unsigned TAG_W      = ADDR_W - IDX_W - OFS_W;
  localparam int unsigned SP_IDX_W   = $clog2(SP_BYTES) - $clog2(WORD_BYTES);
  localparam int unsigned SP_TAG_W   = ADDR_W - $clog2(SP_BYTES);

  // Values after reset
  localparam logic RST_READY = 1'h1;
  localparam logic RST_FLAG  = 1'h0;

  // Per-region cache protocol
  typedef enum logic [1:0] {
    CPSC_UNCACHED   = 2'h0,
    CPSC_WT_NOALLOC = 2'h1,
    CPSC_WT_ALLOC   = 2'h2,
    CPSC_WB_ALLOC   = 2'h3
  } cpsc_policy_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INDEX  = 3'h1,
    ST_TAG    = 3'h2,
    ST_MEMRD  = 3'h3,
    ST_MEMWR  = 3'h4,
    ST_WBACK  = 3'h5,
    ST_REFILL = 3'h6,
    ST_SPWR   = 3'h7
  } cpsc_state_t;

  // Pipeline request and answer
  typedef struct packed {
    logic               valid;
    logic               we;
    logic               lock;
    cpsc_policy_t       policy;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wdata;
  } cpsc_req_t;

  typedef struct packed {
    logic               ready;
    logic               ack;
    logic [31:0]        rdata;
  } cpsc_rsp_t;

  // Main memory word port
  typedef struct packed {
    logic               req;
    logic               we;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        wdata;
  } cpsc_mem_req_t;

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
  } cpsc_mem_rsp_t;

  // Scratchpad port
  typedef struct packed {
    logic                 access;
    logic                 we;
    logic [SP_IDX_W-1:0]  index;
    logic [SP_TAG_W-1:0]  tag;
    logic [31:0]          wdata;
  } cpsc_sp_out_t;

  typedef struct packed {
    logic               hit;
    logic               stall;
    logic [31:0]        rdata;
  } cpsc_sp_in_t;

endpackage

/* File: rtl/cpsc_ctrl.sv */
// Cache protocol controller for one side and the top with instruction and data sides
`timescale 1ns/1ns

module cpsc_side
  import cpsc_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  input  wire logic           sp_en,
  input  wire cpsc_req_t      req_i,
  output cpsc_rsp_t           rsp_o,
  output cpsc_mem_req_t       mem_o,
  input  wire cpsc_mem_rsp_t  mem_i,
  output cpsc_sp_out_t        sp_o,
  input  wire cpsc_sp_in_t    sp_i
);

  // Choose a victim way: {ok, way}; skips locked lines and the scratchpad way
  function automatic logic [1:0] pick_victim(input logic lk0, input logic lk1, input logic sp, input logic lru);
    logic c0;
    logic c1;
    c0 = !lk0;
    c1 = !lk1 && !sp;
    if (c0 && c1)
      return {1'h1, lru};
    else if (c0)
      return 2'h2;
    else if (c1)
      return 2'h3;
    else
      return 2'h0;
  endfunction

  cpsc_state_t            state_q;
  cpsc_req_t              req_q;
  cpsc_rsp_t              rsp_q;
  cpsc_mem_req_t          mem_q;
  cpsc_sp_out_t           sp_q;
  logic [WSEL_W-1:0]      cnt_q;
  logic                   vway_q;
  logic [31:0]            wb_buf_q [WORDS];
  logic [31:0]            data_q   [WAYS][SETS][WORDS];
  logic [TAG_W-1:0]       tagm_q   [WAYS][SETS];
  logic                   valid_q  [WAYS][SETS];
  logic                   dirty_q  [WAYS][SETS];
  logic                   lock_q   [WAYS][SETS];
  logic                   lru_q    [SETS];

  logic [IDX_W-1:0]       idx;
  logic [TAG_W-1:0]       tg;
  logic [WSEL_W-1:0]      wsel;
  logic [WAYS-1:0]        hit;
  logic                   hway;
  logic                   anyhit;
  logic                   cached;
  logic                   sp_hit;
  logic                   tag_go;
  logic [1:0]             vsel;
  logic                   vdirty;
  logic                   st_hit;
  logic                   wr_hit;
  logic                   alloc;
  logic                   fill_ack;
  logic                   fill_done;

  assign rsp_o = rsp_q;
  assign mem_o = mem_q;
  assign sp_o  = sp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lookup decode
  assign idx    = req_q.addr[OFS_W +: IDX_W];
  assign tg     = req_q.addr[ADDR_W-1 -: TAG_W];
  assign wsel   = req_q.addr[2 +: WSEL_W];

  // Per-way tag compare; the scratchpad way is masked out of the cache
  for (genvar w = 0; w < WAYS; w++) begin : g_hit
    assign hit[w] = valid_q[w][idx] && (tagm_q[w][idx] == tg) && !(sp_en && (w == SP_WAY));
  end

  assign hway      = hit[1];
  assign anyhit    = |hit;
  assign cached    = (req_q.policy != CPSC_UNCACHED);
  assign sp_hit    = sp_en && sp_i.hit;
  assign tag_go    = (state_q == ST_TAG) && !(sp_en && sp_i.stall);
  assign vsel      = pick_victim(lock_q[0][idx], lock_q[1][idx], sp_en, lru_q[idx]);
  assign vdirty    = valid_q[vsel[0]][idx] && dirty_q[vsel[0]][idx];
  assign st_hit    = tag_go && !sp_hit && cached && anyhit;
  assign wr_hit    = st_hit && req_q.we && !req_q.lock;
  assign alloc     = tag_go && !sp_hit && cached && !anyhit && vsel[1]
                     && !(req_q.we && (req_q.policy == CPSC_WT_NOALLOC));
  assign fill_ack  = (state_q == ST_REFILL) && mem_i.ack;
  assign fill_done = fill_ack && (cnt_q == WSEL_W'(WORDS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Control sequence and registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_IDLE;
      req_q      <= '0;
      rsp_q      <= '0;
      rsp_q.ready <= RST_READY;
      mem_q      <= '0;
      sp_q       <= '0;
      cnt_q      <= '0;
      vway_q     <= RST_FLAG;
    end else begin
      rsp_q.ack <= 1'h0;
      case (state_q)
        ST_IDLE: begin
          if (req_i.valid && rsp_q.ready) begin
            req_q       <= req_i;
            rsp_q.ready <= 1'h0;
            sp_q.access <= 1'h1;
            sp_q.index  <= req_i.addr[2 +: SP_IDX_W];
            state_q     <= ST_INDEX;
          end
        end
        ST_INDEX: begin
          sp_q.tag <= req_q.addr[ADDR_W-1 -: SP_TAG_W];
          state_q  <= ST_TAG;
        end
        ST_TAG: begin
          if (tag_go) begin
            if (sp_hit) begin
              if (req_q.we) begin
                sp_q.we    <= 1'h1;
                sp_q.wdata <= req_q.wdata;
                state_q    <= ST_SPWR;
              end else begin
                rsp_q       <= '{ready: 1'h1, ack: 1'h1, rdata: sp_i.rdata};
                sp_q.access <= 1'h0;
                state_q     <= ST_IDLE;
              end
            end else if (!cached || (!anyhit && !vsel[1])) begin
              // Uncached or no victim way (way 0 locked and way 1 locked or scratchpad): single word to memory
              sp_q.access <= 1'h0;
              mem_q       <= '{req: 1'h1, we: req_q.we, addr: req_q.addr, wdata: req_q.wdata};
              state_q     <= req_q.we ? ST_MEMWR : ST_MEMRD;
            end else if (anyhit) begin
              sp_q.access <= 1'h0;
              if (!req_q.we || req_q.lock || (req_q.policy == CPSC_WB_ALLOC)) begin
                rsp_q   <= '{ready: 1'h1, ack: 1'h1, rdata: data_q[hway][idx][wsel]};
                state_q <= ST_IDLE;
              end else begin
                mem_q   <= '{req: 1'h1, we: 1'h1, addr: req_q.addr, wdata: req_q.wdata};
                state_q <= ST_MEMWR;
              end
            end else if (!alloc) begin
              sp_q.access <= 1'h0;
              mem_q       <= '{req: 1'h1, we: 1'h1, addr: req_q.addr, wdata: req_q.wdata};
              state_q     <= ST_MEMWR;
            end else begin
              vway_q <= vsel[0];
              cnt_q  <= '0;
              if (vdirty) begin
                mem_q   <= '{req: 1'h1, we: 1'h1, addr: {tagm_q[vsel[0]][idx], idx, {WSEL_W{1'h0}}, 2'h0},
                             wdata: data_q[vsel[0]][idx][0]};
                state_q <= ST_WBACK;
              end else begin
                mem_q   <= '{req: 1'h1, we: 1'h0, addr: {tg, idx, {WSEL_W{1'h0}}, 2'h0}, wdata: 32'h0};
                state_q <= ST_REFILL;
              end
            end
          end
        end
        ST_MEMRD, ST_MEMWR: begin
          if (mem_i.ack) begin
            mem_q.req <= 1'h0;
            rsp_q     <= '{ready: 1'h1, ack: 1'h1, rdata: (state_q == ST_MEMRD) ? mem_i.rdata : rsp_q.rdata};
            state_q   <= ST_IDLE;
          end
        end
        ST_WBACK: begin
          if (mem_i.ack) begin
            cnt_q <= WSEL_W'(cnt_q + 1'h1);
            if (cnt_q == WSEL_W'(WORDS - 1)) begin
              mem_q <= '{req: 1'h1, we: 1'h0, addr: {tg, idx, {WSEL_W{1'h0}}, 2'h0}, wdata: 32'h0};
              state_q <= ST_REFILL;
            end else begin
              mem_q.addr  <= {mem_q.addr[ADDR_W-1:OFS_W], WSEL_W'(cnt_q + 1'h1), 2'h0};
              mem_q.wdata <= wb_buf_q[WSEL_W'(cnt_q + 1'h1)];
            end
          end
        end
        ST_REFILL: begin
          if (mem_i.ack) begin
            cnt_q <= WSEL_W'(cnt_q + 1'h1);
            if (fill_done) begin
              mem_q.req <= 1'h0;
              state_q   <= ST_INDEX;   // Replay the lookup, now a hit
            end else begin
              mem_q.addr <= {mem_q.addr[ADDR_W-1:OFS_W], WSEL_W'(cnt_q + 1'h1), 2'h0};
            end
          end
        end
        ST_SPWR: begin
          if (!sp_i.stall) begin
            sp_q.we     <= 1'h0;
            sp_q.access <= 1'h0;
            rsp_q.ready <= 1'h1;
            rsp_q.ack   <= 1'h1;
            state_q     <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Victim line capture before any refill word lands
  always_ff @(posedge ref_clk) begin
    if (alloc) begin
      for (int i = 0; i < WORDS; i++) begin
        wb_buf_q[i] <= data_q[vsel[0]][idx][i];
      end
    end
  end

  // Data and tag arrays
  always_ff @(posedge ref_clk) begin
    if (wr_hit) begin
      data_q[hway][idx][wsel] <= req_q.wdata;
    end
    if (fill_ack) begin
      data_q[vway_q][idx][cnt_q] <= mem_i.rdata;
    end
    if (fill_done) begin
      tagm_q[vway_q][idx] <= tg;
    end
  end

  // Line state: valid, dirty, lock and replacement order
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < SETS; s++) begin
        lru_q[s] <= RST_FLAG;
        for (int w = 0; w < WAYS; w++) begin
          valid_q[w][s] <= RST_FLAG;
          dirty_q[w][s] <= RST_FLAG;
          lock_q[w][s]  <= RST_FLAG;
        end
      end
    end else begin
      if (alloc) begin
        valid_q[vsel[0]][idx] <= 1'h0;
      end
      if (fill_done) begin
        valid_q[vway_q][idx] <= 1'h1;
        dirty_q[vway_q][idx] <= 1'h0;
        lock_q[vway_q][idx]  <= 1'h0;
        lru_q[idx]           <= !vway_q;
      end
      if (st_hit) begin
        lru_q[idx] <= !hway;
        if (req_q.lock) begin
          lock_q[hway][idx] <= 1'h1;
        end
      end
      if (wr_hit && (req_q.policy == CPSC_WB_ALLOC)) begin
        dirty_q[hway][idx] <= 1'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_tag_after_index: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_INDEX) |=> (state_q == ST_TAG) && (sp_q.tag == $past(req_q.addr[ADDR_W-1 -: SP_TAG_W])))
    else $error("scratchpad tag not driven after index");
  chk_stall_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_TAG) && sp_en && sp_i.stall |=> (state_q == ST_TAG) && !rsp_q.ack)
    else $error("pipeline not held during scratchpad stall");
  chk_sp_store_nomem: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tag_go && sp_hit && req_q.we |=> (state_q == ST_SPWR) ##1 !mem_q.req)
    else $error("scratchpad store reached main memory");
  chk_uncached_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tag_go && !sp_hit && !cached |=> mem_q.req && (mem_q.addr == req_q.addr) && !rsp_q.ack)
    else $error("uncached access not sent to memory");
  chk_load_hit_nomem: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_hit && !req_q.we |=> rsp_q.ack && !mem_q.req && (state_q == ST_IDLE))
    else $error("cached load hit went to memory");
  chk_wt_hit_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_hit && (req_q.policy != CPSC_WB_ALLOC) |=> mem_q.req && mem_q.we && (state_q == ST_MEMWR))
    else $error("write-through hit did not write memory");
  chk_wb_hit_local: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_hit && (req_q.policy == CPSC_WB_ALLOC) |=> !mem_q.req && rsp_q.ack && dirty_q[$past(hway)][idx])
    else $error("write-back hit wrote memory or left line clean");
  chk_wtna_miss: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tag_go && !sp_hit && cached && !anyhit && req_q.we && (req_q.policy == CPSC_WT_NOALLOC)
    |=> (state_q == ST_MEMWR) && mem_q.we)
    else $error("write-through no-allocate miss allocated");
  chk_dirty_wback: assert property (@(posedge ref_clk) disable iff (!arst_n)
    alloc && vdirty |=> (state_q == ST_WBACK) && mem_q.we)
    else $error("dirty victim not written back");
  chk_victim_legal: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_REFILL) |-> !(sp_en && (vway_q == 1'(SP_WAY))) && !lock_q[vway_q][idx])
    else $error("scratchpad or locked way chosen as victim");

endmodule // cpsc_side

module cpsc_ctrl
  import cpsc_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  input  wire logic           i_sp_en,
  input  wire logic           d_sp_en,
  input  wire cpsc_req_t      i_req,
  output cpsc_rsp_t           i_rsp,
  output cpsc_mem_req_t       i_mem_req,
  input  wire cpsc_mem_rsp_t  i_mem_rsp,
  output cpsc_sp_out_t        i_sp_out,
  input  wire cpsc_sp_in_t    i_sp_in,
  input  wire cpsc_req_t      d_req,
  output cpsc_rsp_t           d_rsp,
  output cpsc_mem_req_t       d_mem_req,
  input  wire cpsc_mem_rsp_t  d_mem_rsp,
  output cpsc_sp_out_t        d_sp_out,
  input  wire cpsc_sp_in_t    d_sp_in
);

  logic [1:0] sp_en_s1_q;
  logic [1:0] sp_en_q;

  // Scratchpad enable pins pass two flip-flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_en_s1_q <= 2'h0;
      sp_en_q    <= 2'h0;
    end else begin
      sp_en_s1_q <= {d_sp_en, i_sp_en};
      sp_en_q    <= sp_en_s1_q;
    end
  end

  // Independent instruction and data sides
  cpsc_side u_iside (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .sp_en   (sp_en_q[0]),
    .req_i   (i_req),
    .rsp_o   (i_rsp),
    .mem_o   (i_mem_req),
    .mem_i   (i_mem_rsp),
    .sp_o    (i_sp_out),
    .sp_i    (i_sp_in)
  );

  cpsc_side u_dside (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .sp_en   (sp_en_q[1]),
    .req_i   (d_req),
    .rsp_o   (d_rsp),
    .mem_o   (d_mem_req),
    .mem_i   (d_mem_rsp),
    .sp_o    (d_sp_out),
    .sp_i    (d_sp_in)
  );

endmodule // cpsc_ctrl

/* File: sim/cpsc_sp_model.sv */
// Scratchpad and main memory models that stand at the far side of the controller
`timescale 1ns/1ns

module cpsc_sp_model
  import cpsc_pkg::*;
#(
  parameter logic [SP_TAG_W-1:0] HIT_TAG = 12'h001
)(
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic [3:0]    stall_cycles,
  input  wire cpsc_sp_out_t  sp_o,
  output cpsc_sp_in_t        sp_i
);
  logic [31:0] ram_q [16];
  logic [3:0]  cnt_q;
  logic [31:0] last_q;
  logic [3:0]  ent;
  logic        live;

  // Entry uses a high index bit so the wide index is exercised
  assign ent  = {sp_o.index[17], sp_o.index[2:0]};
  assign live = sp_o.access && (cnt_q != 4'h0);
  // Hit and data only from the second cycle; released data is scrambled
  // Backstall for the chosen number of cycles; one driver for the whole answer
  assign sp_i = '{hit:   live && (sp_o.tag == HIT_TAG),
                  stall: live && (cnt_q <= stall_cycles),
                  rdata: live ? ram_q[ent] : ~last_q};

  // Cycle count within an access, storage of written words
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 4'h0;
      last_q <= 32'h0;
      for (int i = 0; i < 16; i++) ram_q[i] <= 32'h5000_0000 | 32'(i);
    end else begin
      last_q <= sp_i.rdata;
      if (!sp_o.access) cnt_q <= 4'h0;
      else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
      if (sp_i.hit && sp_o.we && !sp_i.stall) ram_q[ent] <= sp_o.wdata;
    end
  end
endmodule // cpsc_sp_model

////////////////////////////////////////////////////////////////////////////////

module cpsc_mem_model
  import cpsc_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  input  wire cpsc_mem_req_t  mem_o,
  output cpsc_mem_rsp_t       mem_i,
  output logic [7:0]          rd_cnt,
  output logic [7:0]          wr_cnt,
  output logic [31:0]         last_wa,
  output logic [31:0]         last_wd
);
  logic ack_q;

  // Data is valid only with ack
  assign mem_i = '{ack:   ack_q,
                   rdata: ack_q ? (mem_o.addr ^ 32'h3C3C_0000) : ~(mem_o.addr ^ 32'h3C3C_0000)};

  // One wait cycle per word, log of completed words
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'h0;
      rd_cnt  <= 8'h0;
      wr_cnt  <= 8'h0;
      last_wa <= 32'h0;
      last_wd <= 32'h0;
    end else begin
      ack_q <= mem_o.req && !ack_q;
      if (ack_q && mem_o.req && mem_o.we) begin
        wr_cnt  <= wr_cnt + 8'h1;
        last_wa <= mem_o.addr;
        last_wd <= mem_o.wdata;
      end else if (ack_q && mem_o.req) begin
        rd_cnt <= rd_cnt + 8'h1;
      end
    end
  end
endmodule // cpsc_mem_model

/* File: sim/cpsc_ctrl_bench.sv */
// Self-checking bench for the cache policy and scratchpad controller
`timescale 1ns/1ns

module cpsc_ctrl_bench
  import cpsc_pkg::*;
;
  logic          ref_clk = 1'h0;
  logic          arst_n  = 1'h0;
  logic          i_sp_en = 1'h1;
  logic          d_sp_en = 1'h1;
  logic [3:0]    i_stl   = 4'h0;
  logic [3:0]    d_stl   = 4'h0;
  cpsc_req_t     i_req   = '0;
  cpsc_req_t     d_req   = '0;
  cpsc_rsp_t     i_rsp, d_rsp;
  cpsc_mem_req_t i_mo, d_mo;
  cpsc_mem_rsp_t i_mi, d_mi;
  cpsc_sp_out_t  i_so, d_so;
  cpsc_sp_in_t   i_si, d_si;
  logic [7:0]    rd [2];
  logic [7:0]    wr [2];
  logic [31:0]   wa [2];
  logic [31:0]   wd [2];
  logic [7:0]    rd0, wr0;
  logic [31:0]   v;
  int            lat, cyc = 0, checks = 0, miscompares = 0;
  localparam logic [31:0] A0 = 32'h0000_1040, A1 = 32'h0000_2040, SP = 32'h0010_0000;

  always #10 ref_clk = ~ref_clk;

  cpsc_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .i_sp_en(i_sp_en), .d_sp_en(d_sp_en),
    .i_req(i_req), .i_rsp(i_rsp), .i_mem_req(i_mo), .i_mem_rsp(i_mi), .i_sp_out(i_so), .i_sp_in(i_si),
    .d_req(d_req), .d_rsp(d_rsp), .d_mem_req(d_mo), .d_mem_rsp(d_mi), .d_sp_out(d_so), .d_sp_in(d_si));
  cpsc_sp_model i_sp_u (.ref_clk(ref_clk), .arst_n(arst_n), .stall_cycles(i_stl), .sp_o(i_so), .sp_i(i_si));
  cpsc_sp_model d_sp_u (.ref_clk(ref_clk), .arst_n(arst_n), .stall_cycles(d_stl), .sp_o(d_so), .sp_i(d_si));
  cpsc_mem_model i_mem_u (.ref_clk(ref_clk), .arst_n(arst_n), .mem_o(i_mo), .mem_i(i_mi),
    .rd_cnt(rd[1]), .wr_cnt(wr[1]), .last_wa(wa[1]), .last_wd(wd[1]));
  cpsc_mem_model d_mem_u (.ref_clk(ref_clk), .arst_n(arst_n), .mem_o(d_mo), .mem_i(d_mi),
    .rd_cnt(rd[0]), .wr_cnt(wr[0]), .last_wa(wa[0]), .last_wd(wd[0]));

  ////////////////////////////////////////////////////////////////////////////////

  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Single compare of a 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mpat(input logic [31:0] a);
    return a ^ 32'h3C3C_0000;
  endfunction

  // One pipeline request; returns data and cycles to ack
  task automatic xfer(input bit s, input logic we, input cpsc_policy_t p, input logic [31:0] a,
                      input logic [31:0] w, input logic lk);
    cpsc_req_t r;
    r = '{valid: 1'h1, we: we, lock: lk, policy: p, addr: a, wdata: w};
    rd0 = rd[s];
    wr0 = wr[s];
    @(posedge ref_clk);
    if (s) i_req <= r;
    else d_req <= r;
    @(posedge ref_clk);
    if (s) i_req.valid <= 1'h0;
    else d_req.valid <= 1'h0;
    // Cycle of the ack: the taking cycle is 1, the index cycle 2, the tag cycle 3
    for (lat = 2; lat < 300; lat++) begin
      @(posedge ref_clk);
      #1;
      if ((s ? i_rsp.ack : d_rsp.ack) === 1'h1) break;
    end
    // An answer that never comes counts as a mismatch
    if (lat == 300) miscompares++;
    v = s ? i_rsp.rdata : d_rsp.rdata;
  endtask

  // Memory words read and written during the last request
  task automatic mem_chk(input bit s, input logic [7:0] er, input logic [7:0] ew);
    chk({24'h0, rd[s] - rd0}, {24'h0, er});
    chk({24'h0, wr[s] - wr0}, {24'h0, ew});
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  // Scratchpad lookups, backstall, stores with the wide index
  task automatic t_scratch();
    xfer(0, 0, CPSC_WT_NOALLOC, SP | 32'h8, 0, 0);
    chk(32'(lat), 32'h3);
    chk(v, 32'h5000_0002);
    d_stl <= 4'h2;
    xfer(0, 0, CPSC_WB_ALLOC, SP | 32'h8, 0, 0);
    chk(32'(lat), 32'h5);
    chk(32'(d_rsp.ready), 32'h1);
    d_stl <= 4'h0;
    xfer(0, 1, CPSC_WT_ALLOC, SP | 32'h0008_0014, 32'hCAFE_0001, 0);
    chk(32'(lat), 32'h4);
    mem_chk(0, 0, 0);
    xfer(0, 0, CPSC_WT_NOALLOC, SP | 32'h0008_0014, 0, 0);
    chk(v, 32'hCAFE_0001);
    xfer(0, 0, CPSC_WT_NOALLOC, SP | 32'h14, 0, 0);
    chk(v, 32'h5000_0005);
    mem_chk(0, 0, 0);
  endtask

  // Cached lookup against uncached access, write-through without allocate
  task automatic t_through();
    xfer(0, 0, CPSC_WT_NOALLOC, A0, 0, 0);
    mem_chk(0, 4, 0);
    xfer(0, 0, CPSC_WT_NOALLOC, A0, 0, 0);
    mem_chk(0, 0, 0);
    xfer(0, 1, CPSC_UNCACHED, A0, 32'h1111_0000, 0);
    mem_chk(0, 0, 1);
    xfer(0, 0, CPSC_WT_NOALLOC, A0, 0, 0);
    chk(v, mpat(A0));
    xfer(0, 0, CPSC_UNCACHED, A0, 0, 0);
    mem_chk(0, 1, 0);
    xfer(0, 1, CPSC_WT_NOALLOC, A0 + 4, 32'h2222_0000, 0);
    mem_chk(0, 0, 1);
    xfer(0, 0, CPSC_WT_NOALLOC, A0 + 4, 0, 0);
    chk(v, 32'h2222_0000);
    xfer(0, 1, CPSC_WT_NOALLOC, A1, 32'h3333_0000, 0);
    mem_chk(0, 0, 1);
    xfer(0, 0, CPSC_WT_NOALLOC, A1, 0, 0);
    chk(v, mpat(A1));
    mem_chk(0, 4, 0);
  endtask

  // Write-back dirty eviction and write-through allocate
  task automatic t_back();
    xfer(0, 1, CPSC_WB_ALLOC, A0 + 12, 32'h4444_0000, 0);
    mem_chk(0, 4, 0);
    xfer(0, 0, CPSC_WB_ALLOC, A1, 0, 0);
    mem_chk(0, 4, 4);
    chk(wa[0], A0 + 12);
    chk(wd[0], 32'h4444_0000);
    xfer(0, 1, CPSC_WT_ALLOC, A0 + 8, 32'h5555_0000, 0);
    mem_chk(0, 4, 1);
    chk(wd[0], 32'h5555_0000);
    xfer(0, 0, CPSC_WT_ALLOC, A0 + 8, 0, 0);
    chk(v, 32'h5555_0000);
  endtask

  // Locked line is kept; scratchpad off turns a scratchpad address into a cached line fill
  task automatic t_lock();
    xfer(0, 0, CPSC_WT_NOALLOC, A1, 0, 1);
    mem_chk(0, 4, 0);
    xfer(0, 0, CPSC_WT_NOALLOC, A0, 0, 0);
    mem_chk(0, 1, 0);
    chk(v, mpat(A0));
    xfer(0, 1, CPSC_WB_ALLOC, A1 + 4, 32'h6666_0000, 0);
    xfer(0, 0, CPSC_WB_ALLOC, A1 + 4, 0, 0);
    chk(v, 32'h6666_0000);
    mem_chk(0, 0, 0);
    @(posedge ref_clk);
    d_sp_en <= 1'h0;
    repeat (4) @(posedge ref_clk);
    xfer(0, 0, CPSC_WT_NOALLOC, SP | 32'h8, 0, 0);
    chk(v, mpat(SP | 32'h8));
    mem_chk(0, 4, 0);
  endtask

  // Instruction side has its own scratchpad and memory port
  task automatic t_inst();
    xfer(1, 0, CPSC_WT_NOALLOC, SP | 32'h4, 0, 0);
    chk(32'(lat), 32'h3);
    chk(v, 32'h5000_0001);
    xfer(1, 0, CPSC_WT_NOALLOC, 32'h0000_0404, 0, 0);
    chk(v, mpat(32'h0000_0404));
    mem_chk(1, 4, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
    t_scratch();
    t_through();
    t_back();
    t_lock();
    t_inst();
    summarize();
  end
endmodule // cpsc_ctrl_bench
